/* hdl/gcs_pkg.sv */
package gcs_pkg;

  // ----------------------------------------
  // Management addresses
  // ----------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_GCTL = 5'h09;
  localparam logic [4:0] ADDR_GSTAT = 5'h0A;
  localparam logic [4:0] ADDR_RSVD_LO_FIRST = 5'h0B;
  localparam logic [4:0] ADDR_RSVD_LO_LAST = 5'h0E;
  localparam logic [4:0] ADDR_XSTAT = 5'h0F;
  localparam logic [4:0] ADDR_RSVD_HI_FIRST = 5'h10;
  localparam logic [4:0] ADDR_RSVD_HI_LAST = 5'h12;

  // ----------------------------------------
  // Gigabit control field positions
  // ----------------------------------------
  localparam int GCTL_TEST_HI = 15;
  localparam int GCTL_TEST_LO = 13;
  localparam int GCTL_MS_MANUAL = 12;
  localparam int GCTL_MS_VALUE = 11;
  localparam int GCTL_PORT_TYPE = 10;
  localparam int GCTL_ADV_FD = 9;
  localparam int GCTL_ADV_HD = 8;

  // ----------------------------------------
  // Gigabit status field positions
  // ----------------------------------------
  localparam int GSTAT_FAULT = 15;
  localparam int GSTAT_RES_MASTER = 14;
  localparam int GSTAT_LOCAL_OK = 13;
  localparam int GSTAT_REMOTE_OK = 12;
  localparam int GSTAT_LP_FD = 11;
  localparam int GSTAT_LP_HD = 10;
  localparam int GSTAT_IDLE_HI = 7;
  localparam int GSTAT_IDLE_LO = 0;
  localparam int IDLE_W = 8;
  localparam logic [7:0] IDLE_MAX = 8'hFF;

  // ----------------------------------------
  // Extended status field positions
  // ----------------------------------------
  localparam int XSTAT_X_FD = 15;
  localparam int XSTAT_X_HD = 14;
  localparam int XSTAT_T_FD = 13;
  localparam int XSTAT_T_HD = 12;
  localparam logic XSTAT_T_HD_VAL = 1'b1;

  // ----------------------------------------
  // Reset values and limits of plain control fields
  // ----------------------------------------
  localparam logic [2:0] TEST_NORMAL = 3'h0;
  localparam logic [2:0] TEST_LAST = 3'h4;
  localparam logic MS_MANUAL_RST = 1'b0;
  localparam logic [15:0] REG_ZERO = 16'h0000;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] test_mode;
    logic ms_manual;
    logic ms_value_master;
    logic ms_force_master;
    logic ms_force_slave;
    logic port_multiport;
    logic adv_1000fd;
    logic adv_1000hd;
  } gcs_ctrl_s;

  typedef struct packed {
    logic ms_fault_evt;
    logic resolved_master;
    logic local_rx_ok;
    logic remote_rx_ok;
    logic lp_1000fd;
    logic lp_1000hd;
    logic idle_err_evt;
    logic an_complete_evt;
    logic an_enable_evt;
  } gcs_link_s;

  typedef struct packed {
    logic master_pref;
    logic speed_1000;
    logic duplex;
  } gcs_strap_s;

endpackage : gcs_pkg

/* hdl/gcs_regs.sv */
`timescale 1ns/10ps
module gcs_regs
  import gcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Strap pins, sampled while reset is held
  input wire gcs_strap_s straps,
  // Management register port
  input wire logic [ADDR_W-1:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  // Status from the line side
  input wire gcs_link_s link,
  // Control to the line side
  output gcs_ctrl_s ctrl
);

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic wr_gctl;
  logic rd_gstat;
  logic in_rsvd;

  // Only control bits 15:8 are writable; everything else is dropped
  assign wr_gctl = mgmt_wr && (mgmt_addr == ADDR_GCTL);
  assign rd_gstat = mgmt_rd && (mgmt_addr == ADDR_GSTAT);
  assign in_rsvd =
    ((mgmt_addr >= ADDR_RSVD_LO_FIRST) && (mgmt_addr <= ADDR_RSVD_LO_LAST)) ||
    ((mgmt_addr >= ADDR_RSVD_HI_FIRST) && (mgmt_addr <= ADDR_RSVD_HI_LAST));

  // ------------------------------------------------------------
  // Gigabit control register
  // ------------------------------------------------------------
  logic [2:0] test_mode;
  logic ms_manual;
  logic ms_value;
  logic port_type;
  logic adv_fd;
  logic adv_hd;
  logic strap_fd;

  // Reset is synchronous, so straps are caught by this clocked load
  always_ff @(posedge clk) begin
    if (srst) begin
      test_mode <= TEST_NORMAL;
      ms_manual <= MS_MANUAL_RST;
      ms_value <= straps.master_pref;
      port_type <= straps.master_pref;
      adv_fd <= straps.speed_1000 & straps.duplex;
      adv_hd <= straps.speed_1000;
    end else if (wr_gctl) begin
      test_mode <= mgmt_wdata[GCTL_TEST_HI:GCTL_TEST_LO];
      ms_manual <= mgmt_wdata[GCTL_MS_MANUAL];
      ms_value <= mgmt_wdata[GCTL_MS_VALUE];
      port_type <= mgmt_wdata[GCTL_PORT_TYPE];
      adv_fd <= mgmt_wdata[GCTL_ADV_FD];
      adv_hd <= mgmt_wdata[GCTL_ADV_HD];
    end
  end

  // Extended ability follows the same straps, frozen at reset
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_fd <= straps.speed_1000 & straps.duplex;
    end
  end

  // ------------------------------------------------------------
  // Control outputs, registered from the next state
  // ------------------------------------------------------------
  gcs_ctrl_s next_ctrl;
  logic [2:0] next_test;
  logic next_manual;
  logic next_value;

  always_comb begin
    next_test = wr_gctl ? mgmt_wdata[GCTL_TEST_HI:GCTL_TEST_LO] : test_mode;
    next_manual = wr_gctl ? mgmt_wdata[GCTL_MS_MANUAL] : ms_manual;
    next_value = wr_gctl ? mgmt_wdata[GCTL_MS_VALUE] : ms_value;
    // Reserved test codes fall back to normal so the line never sees them
    if (next_test > TEST_LAST) begin
      next_ctrl.test_mode = TEST_NORMAL;
    end else begin
      next_ctrl.test_mode = next_test;
    end
    next_ctrl.ms_manual = next_manual;
    next_ctrl.ms_value_master = next_value;
    next_ctrl.ms_force_master = next_manual & next_value;
    next_ctrl.ms_force_slave = next_manual & ~next_value;
    next_ctrl.port_multiport =
      wr_gctl ? mgmt_wdata[GCTL_PORT_TYPE] : port_type;
    next_ctrl.adv_1000fd = wr_gctl ? mgmt_wdata[GCTL_ADV_FD] : adv_fd;
    next_ctrl.adv_1000hd = wr_gctl ? mgmt_wdata[GCTL_ADV_HD] : adv_hd;
  end

  // Straps are not reachable here in reset, so outputs lag one edge
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= '0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ------------------------------------------------------------
  // Latched configuration fault
  // ------------------------------------------------------------
  logic ms_fault;

  // A fault in the same cycle as any clear but srst still lands
  always_ff @(posedge clk) begin
    if (srst) begin
      ms_fault <= 1'b0;
    end else if (link.ms_fault_evt) begin
      ms_fault <= 1'b1;
    end else if (rd_gstat || link.an_complete_evt || link.an_enable_evt) begin
      ms_fault <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Idle error counter
  // ------------------------------------------------------------
  logic [IDLE_W-1:0] idle_cnt;
  logic idle_count_en;

  assign idle_count_en =
    link.idle_err_evt && link.local_rx_ok && link.remote_rx_ok;

  // A same-cycle read clear restarts the count at 1, so no error is lost
  always_ff @(posedge clk) begin
    if (srst) begin
      idle_cnt <= '0;
    end else if (rd_gstat) begin
      idle_cnt <= idle_count_en ? 8'h01 : 8'h00;
    end else if (idle_count_en && (idle_cnt != IDLE_MAX)) begin
      idle_cnt <= idle_cnt + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Read data assembly
  // ------------------------------------------------------------
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = REG_ZERO;
    if (mgmt_addr == ADDR_GCTL) begin
      next_rdata[GCTL_TEST_HI:GCTL_TEST_LO] = test_mode;
      next_rdata[GCTL_MS_MANUAL] = ms_manual;
      next_rdata[GCTL_MS_VALUE] = ms_value;
      next_rdata[GCTL_PORT_TYPE] = port_type;
      next_rdata[GCTL_ADV_FD] = adv_fd;
      next_rdata[GCTL_ADV_HD] = adv_hd;
    end else if (mgmt_addr == ADDR_GSTAT) begin
      next_rdata[GSTAT_FAULT] = ms_fault;
      // Resolution is only meaningful while no fault is latched
      next_rdata[GSTAT_RES_MASTER] = link.resolved_master;
      next_rdata[GSTAT_LOCAL_OK] = link.local_rx_ok;
      next_rdata[GSTAT_REMOTE_OK] = link.remote_rx_ok;
      next_rdata[GSTAT_LP_FD] = link.lp_1000fd;
      next_rdata[GSTAT_LP_HD] = link.lp_1000hd;
      next_rdata[GSTAT_IDLE_HI:GSTAT_IDLE_LO] = idle_cnt;
    end else if (mgmt_addr == ADDR_XSTAT) begin
      next_rdata[XSTAT_X_FD] = 1'b0;
      next_rdata[XSTAT_X_HD] = 1'b0;
      next_rdata[XSTAT_T_FD] = strap_fd;
      next_rdata[XSTAT_T_HD] = XSTAT_T_HD_VAL;
    end else if (in_rsvd) begin
      next_rdata = REG_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mgmt_rdata <= REG_ZERO;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rvalid <= mgmt_rd;
      if (mgmt_rd) begin
        mgmt_rdata <= next_rdata;
      end
    end
  end

endmodule : gcs_regs

/* testbench/gcs_mgmt_model.sv */
`timescale 1ns/10ps
module gcs_mgmt_model
  import gcs_pkg::*;
(
  // Clock
  input wire logic clk,
  // Requests
  output logic [ADDR_W-1:0] mgmt_addr,
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [15:0] mgmt_wdata,
  // Answer
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  initial begin
    mgmt_addr = '0;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_wdata = 16'h0000;
  end
  // Strobes are one cycle wide; data is scrambled once released
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    @(negedge clk);
    mgmt_wr = 1'b0;
    mgmt_wdata = ~d;
  endtask : wr_reg
  // A missing answer turns into unknown so the compare fails
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    @(negedge clk);
    mgmt_rd = 1'b0;
    d = mgmt_rvalid ? mgmt_rdata : 16'hXXXX;
  endtask : rd_reg
endmodule : gcs_mgmt_model

/* testbench/gcs_regs_assertions.sv */
`timescale 1ns/10ps
module gcs_chk
  import gcs_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic srst,
  input wire gcs_strap_s straps,
  input wire logic [ADDR_W-1:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  input wire gcs_link_s link,
  input wire gcs_ctrl_s ctrl
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  wire logic cw = mgmt_wr && mgmt_addr == ADDR_GCTL;
  wire logic [3:0] sx = {straps.master_pref, straps.master_pref,
    straps.speed_1000 & straps.duplex, straps.speed_1000};
  wire logic [2:0] tm = mgmt_wdata[15:13] > TEST_LAST ? TEST_NORMAL :
    mgmt_wdata[15:13];
  a_test_select: assert property (cw |=> ctrl.test_mode == $past(tm))
    else $error("test mode differs from written code");
  a_role_force: assert property (
    ctrl.ms_force_master == (ctrl.ms_manual & ctrl.ms_value_master) &&
    ctrl.ms_force_slave == (ctrl.ms_manual & ~ctrl.ms_value_master))
    else $error("forced role disagrees with manual bits");
  a_ctl_write: assert property (cw |=> {ctrl.ms_manual,
    ctrl.ms_value_master, ctrl.port_multiport, ctrl.adv_1000fd,
    ctrl.adv_1000hd} == $past(mgmt_wdata[12:8]))
    else $error("control bits not taken from write");
  a_strap_load: assert property ($fell(srst) && !mgmt_wr |=>
    {ctrl.ms_value_master, ctrl.port_multiport, ctrl.adv_1000fd,
    ctrl.adv_1000hd} == $past(sx, 2))
    else $error("reset defaults differ from straps");
  a_ctrl_hold: assert property (!cw && !$fell(srst) |=> $stable(ctrl))
    else $error("control changed without a write");
  a_xstat_read: assert property (
    mgmt_rd && mgmt_addr == ADDR_XSTAT |=>
    mgmt_rdata[15:14] == 2'h0 && mgmt_rdata[12] && mgmt_rdata[11:0] == 12'h000)
    else $error("extended status fixed bits wrong");
  a_rsvd_read: assert property (mgmt_rd && mgmt_addr inside
    {[ADDR_RSVD_LO_FIRST:ADDR_RSVD_LO_LAST],
    [ADDR_RSVD_HI_FIRST:ADDR_RSVD_HI_LAST]} |=> mgmt_rdata == REG_ZERO)
    else $error("reserved address read nonzero");
  a_live_status: assert property (
    mgmt_rd && mgmt_addr == ADDR_GSTAT |=>
    mgmt_rdata[13:10] == $past({link.local_rx_ok, link.remote_rx_ok,
    link.lp_1000fd, link.lp_1000hd}))
    else $error("live status bits wrong");
endmodule : gcs_chk

bind gcs_regs gcs_chk chk (.clk, .srst, .straps, .mgmt_addr, .mgmt_wr,
  .mgmt_rd, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .link, .ctrl);

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import gcs_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  gcs_strap_s straps = '0;
  gcs_link_s link = '0;
  logic [ADDR_W-1:0] mgmt_addr;
  logic mgmt_wr;
  logic mgmt_rd;
  logic [15:0] mgmt_wdata;
  logic [15:0] mgmt_rdata;
  logic mgmt_rvalid;
  gcs_ctrl_s ctrl;
  logic [15:0] rd;
  logic [15:0] wv;
  logic [15:0] xs;
  logic [7:0] cnt;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  always #10 clk = ~clk;
  gcs_regs uut (.clk, .srst, .straps, .mgmt_addr, .mgmt_wr, .mgmt_rd,
    .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .link, .ctrl);
  gcs_mgmt_model mdl (.clk, .mgmt_addr, .mgmt_wr, .mgmt_rd, .mgmt_wdata,
    .mgmt_rdata, .mgmt_rvalid);
  // ----
  // Helpers
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end
  function automatic gcs_ctrl_s ctrl_exp(input logic [15:0] w);
    return {w[15:13] > 3'h4 ? 3'h0 : w[15:13], w[12], w[11],
      w[12] & w[11], w[12] & ~w[11], w[10:8]};
  endfunction : ctrl_exp
  function automatic logic [15:0] stat_exp(input logic f, input logic [7:0] c);
    return {f, link.resolved_master, link.local_rx_ok, link.remote_rx_ok,
      link.lp_1000fd, link.lp_1000hd, 2'h0, c};
  endfunction : stat_exp
  // Event held high k cycles back to back, each cycle one event
  task automatic hold_evt(input int b, input int k);
    @(negedge clk);
    link[b] = 1'b1;
    repeat (k) @(negedge clk);
    link[b] = 1'b0;
  endtask : hold_evt
  // Releases a held reset and checks the strap-loaded defaults
  task automatic reset_check();
    repeat (6) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    xs = {2'h0, straps.speed_1000 & straps.duplex, 1'b1, 12'h000};
    mdl.rd_reg(ADDR_GCTL, rd);
    check(rd, {4'h0, {2{straps.master_pref}}, xs[13],
      straps.speed_1000, 8'h00});
    mdl.rd_reg(ADDR_XSTAT, rd);
    check(rd, xs);
  endtask : reset_check
  // ----
  // Tests
  // ----
  initial begin
    void'($urandom(32'h8FF94DC8));
    straps = 3'($urandom);
    reset_check();
    $display("test strap defaults done");
    for (int c = 0; c < 8; c++) begin
      wv = {c[2:0], 13'($urandom)};
      mdl.wr_reg(ADDR_GCTL, wv);
      check(16'(ctrl), 16'(ctrl_exp(wv)));
    end
    for (int a = 10; a < 20; a++) mdl.wr_reg(5'(a), 16'hFFFF);
    check(16'(ctrl), 16'(ctrl_exp(wv)));
    mdl.rd_reg(ADDR_GCTL, rd);
    check(rd, {wv[15:8], 8'h00});
    for (int a = 11; a < 20; a++) begin
      mdl.rd_reg(5'(a), rd);
      check(rd, a == 15 ? xs : 16'h0000);
    end
    $display("test control writes done");
    mdl.rd_reg(ADDR_GSTAT, rd);
    for (int t = 0; t < 8; t++) begin
      link = 9'($urandom) & 9'h0F8;
      link.local_rx_ok = link.local_rx_ok | (t < 2);
      link.remote_rx_ok = link.remote_rx_ok | (t < 2);
      n = (t == 0) ? 300 : $urandom_range(1, 20);
      hold_evt(2, n);
      if (t[0]) hold_evt(8, 1);
      cnt = !(link.local_rx_ok & link.remote_rx_ok) ? 8'h00 :
        (n > 255 ? 8'hFF : 8'(n));
      mdl.rd_reg(ADDR_GSTAT, rd);
      check(rd, stat_exp(t[0], cnt));
      mdl.rd_reg(ADDR_GSTAT, rd);
      check(rd, stat_exp(1'b0, 8'h00));
    end
    for (int b = 0; b < 2; b++) begin
      hold_evt(8, 1);
      hold_evt(b, 1);
      mdl.rd_reg(ADDR_GSTAT, rd);
      check(rd, stat_exp(1'b0, 8'h00));
    end
    // Fault, idle error and status read in one cycle: the events win
    link.local_rx_ok = 1'b1;
    link.remote_rx_ok = 1'b1;
    fork
      hold_evt(8, 1);
      hold_evt(2, 1);
      mdl.rd_reg(ADDR_GSTAT, rd);
    join
    check(rd, stat_exp(1'b0, 8'h00));
    mdl.rd_reg(ADDR_GSTAT, rd);
    check(rd, stat_exp(1'b1, 8'h01));
    $display("test status counters done");
    hold_evt(8, 1);
    hold_evt(2, 3);
    srst = 1'b1;
    straps = 3'($urandom);
    reset_check();
    mdl.rd_reg(ADDR_GSTAT, rd);
    check(rd, stat_exp(1'b0, 8'h00));
    $display("test mid-run reset done");
    conclude();
  end
endmodule : testbench
